// >>> logic/fault_flag_pkg.sv
// Contract
// (R1) periodic known-answer test and output watchdog
// (R2) logic check evaluated every ten updates
// (R3) non-critical flag clears on read or report; the memory single-bit flag clears on read only
// (R4) squared radius from floored channel squares
// (R5) radius valid strictly between squared bounds
// (R6) squared radius readable from a register
// (R7) range check per update, filtered up to sixteen
// (R8) radius mask suppresses range flag
// (R9) reset flag clears only after first update
// (R10) first report after reset shows reset flag
// (R11) reset mask suppresses reset flag
// (R12) pulse-width mode may prolong reset flag
// (R13) multi-bit memory error critical until reset
// (R14) single-bit flag clear-on-read, maskable; multi-bit unmaskable
// (R15) memory flags evaluated only at power-on read
// (R16) shadow parity error critical, maskable
// (R17) shadow parity rechecked every ten updates
// (R18) undervoltage forces error until read or report
// (R19) below reset level output high impedance
// (R20) undervoltage select: 0 low, 1 high thresholds
// (R21) overvoltage flag only when memory locked
// (R22) overvoltage select: 0 high, 1 low thresholds
// (R23) read clears removed non-critical flags
// (R24) comparators synchronized, each flag sticky
// (R25) masked flag not set, check keeps running
package fault_flag_pkg;
	localparam logic [7:0] ADDR_ERROR   = 8'h00;
	localparam logic [7:0] ADDR_RADIUS  = 8'h04;
	localparam logic [7:0] ADDR_CONFIG  = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;
	// error register bit positions
	localparam int BIT_LOGIC   = 4;
	localparam int BIT_RADIUS  = 5;
	localparam int BIT_RESET   = 6;
	localparam int BIT_SINGLE  = 7;
	localparam int BIT_UNDERV  = 8;
	localparam int BIT_OVERV   = 9;
	localparam int BIT_UNCORR  = 10;
	localparam int BIT_PARITY  = 11;
	// config register bit positions
	localparam int CFG_RADIUS_MASK = 0;
	localparam int CFG_SINGLE_MASK = 1;
	localparam int CFG_PARITY_MASK = 2;
	localparam int CFG_RESET_MASK  = 3;
	localparam int CFG_UV_SEL      = 4;
	localparam int CFG_OV_SEL      = 5;
	localparam int CFG_LOCK        = 6;
	localparam int CFG_PWM_MODE    = 7;
	localparam int CFG_FILT_LSB    = 8;
	localparam int CFG_BOUND_LO    = 12;
	localparam int CFG_BOUND_HI    = 20;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam int CHECK_PERIOD    = 10;
	localparam int RADIUS_SHIFT    = 7;
	localparam int WATCHDOG_CYCLES = 64;
	localparam int PWM_HOLD_UPDATES = 4;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> logic/update_counter.sv
`timescale 1ns/100ps
`default_nettype none
// counts update pulses, emits one pulse every PERIOD updates
module update_counter #(
	parameter int PERIOD = 10
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic tick,
	output logic      fire
);
	logic [7:0] count;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= 8'h00;
			fire  <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (tick) begin
				if (count == 8'(PERIOD - 1)) begin
					count <= 8'h00;
					fire  <= 1'b1;
				end else begin
					count <= count + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/sync2.sv
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser for asynchronous comparator levels
module sync2 (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic meta;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> logic/fault_flag_monitor.sv
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fault_flag_monitor (
	input  wire logic        clk,
	input  wire logic        resetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// signal path
	input  wire logic        angle_update,
	input  wire logic [15:0] first_channel_value,
	input  wire logic [15:0] second_channel_value,
	input  wire logic        samples_ready,
	input  wire logic        angle_out_valid,
	input  wire logic [15:0] selftest_result,
	input  wire logic [15:0] selftest_expected,
	// memory load at power on
	input  wire logic        mem_read_done,
	input  wire logic        mem_single_bit,
	input  wire logic        mem_multi_bit,
	input  wire logic        shadow_parity_bad,
	// supply comparators, asynchronous
	input  wire logic        uv_low_trip,
	input  wire logic        uv_high_trip,
	input  wire logic        ov_low_trip,
	input  wire logic        ov_high_trip,
	input  wire logic        por_level_low,
	// output protocol
	input  wire logic        report_sent,
	output logic             error_response,
	output logic             critical_error,
	output logic             output_hiz,
	output logic             program_mode
);
	// ****************************************
	// synchronisers and periodic checks
	// ****************************************
	logic uv_low_s, uv_high_s, ov_low_s, ov_high_s, por_low_s;
	sync2 u_s0 (.clk(clk), .resetn(resetn), .d(uv_low_trip),   .q(uv_low_s));  // R24
	sync2 u_s1 (.clk(clk), .resetn(resetn), .d(uv_high_trip),  .q(uv_high_s));
	sync2 u_s2 (.clk(clk), .resetn(resetn), .d(ov_low_trip),   .q(ov_low_s));
	sync2 u_s3 (.clk(clk), .resetn(resetn), .d(ov_high_trip),  .q(ov_high_s));
	sync2 u_s4 (.clk(clk), .resetn(resetn), .d(por_level_low), .q(por_low_s));

	logic ten_tick;
	update_counter #(.PERIOD(fault_flag_pkg::CHECK_PERIOD)) u_ten (
		.clk(clk), .resetn(resetn), .tick(angle_update), .fire(ten_tick));   // R2 R17

	logic [31:0] config_reg;
	wire radius_mask = config_reg[fault_flag_pkg::CFG_RADIUS_MASK];
	wire single_mask = config_reg[fault_flag_pkg::CFG_SINGLE_MASK];
	wire parity_mask = config_reg[fault_flag_pkg::CFG_PARITY_MASK];
	wire reset_mask  = config_reg[fault_flag_pkg::CFG_RESET_MASK];
	wire uv_sel      = config_reg[fault_flag_pkg::CFG_UV_SEL];
	wire ov_sel      = config_reg[fault_flag_pkg::CFG_OV_SEL];
	wire mem_locked  = config_reg[fault_flag_pkg::CFG_LOCK];
	wire pwm_mode    = config_reg[fault_flag_pkg::CFG_PWM_MODE];
	wire [3:0] fault_filter_setting = config_reg[fault_flag_pkg::CFG_FILT_LSB +: 4];
	wire [7:0] radius_lower_bound   = config_reg[fault_flag_pkg::CFG_BOUND_LO +: 8];
	wire [7:0] radius_upper_bound   = config_reg[fault_flag_pkg::CFG_BOUND_HI +: 8];

	// ****************************************
	// logic self-check and watchdog
	// ****************************************
	logic [7:0] wd_count;
	logic       wd_armed, wd_miss;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_count <= 8'h00;
			wd_armed <= 1'b0;
			wd_miss  <= 1'b0;
		end else begin
			if (samples_ready) begin
				wd_armed <= 1'b1;
				wd_count <= 8'h00;
			end else if (angle_out_valid) begin
				wd_armed <= 1'b0;
			end else if (wd_armed) begin
				wd_count <= wd_count + 8'h01;
			end
			if (wd_armed && wd_count == 8'(fault_flag_pkg::WATCHDOG_CYCLES)) begin
				wd_miss <= 1'b1;                                               // R1
				wd_armed <= 1'b0;
			end else if (ten_tick) begin
				wd_miss <= 1'b0;
			end
		end
	end
	wire logic_cond = ten_tick && ((selftest_result != selftest_expected) || wd_miss); // R1 R2

	// ****************************************
	// squared radius and range check
	// ****************************************
	wire [8:0]  a_floor = first_channel_value[15:fault_flag_pkg::RADIUS_SHIFT];  // R4
	wire [8:0]  b_floor = second_channel_value[15:fault_flag_pkg::RADIUS_SHIFT];
	wire [17:0] sum_sq  = 18'(a_floor * a_floor) + 18'(b_floor * b_floor);
	wire [16:0] next_squared_radius = sum_sq[16:0];
	wire [16:0] lo_sq = 17'(radius_lower_bound * radius_lower_bound);
	wire [16:0] hi_sq = 17'(radius_upper_bound * radius_upper_bound);
	wire radius_ok = (next_squared_radius > lo_sq) && (next_squared_radius < hi_sq); // R5
	logic [16:0] squared_radius;
	logic [4:0]  bad_run;
	logic        radius_cond;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			squared_radius <= 17'h00000;
			bad_run        <= 5'h00;
			radius_cond    <= 1'b0;
		end else if (angle_update) begin
			squared_radius <= next_squared_radius;                           // R6 R7
			bad_run        <= radius_ok ? 5'h00 : (bad_run == 5'h1f ? bad_run : bad_run + 5'h01);
			radius_cond    <= !radius_ok && (bad_run >= {1'b0, fault_filter_setting});  // R7
		end
	end

	// ****************************************
	// supply thresholds
	// ****************************************
	wire uv_cond = uv_sel ? uv_high_s : uv_low_s;                         // R20
	wire ov_trip = ov_sel ? ov_low_s : ov_high_s;                         // R22
	wire ov_cond = ov_trip && mem_locked;                                  // R21

	// ****************************************
	// sticky error flags
	// ****************************************
	logic logic_failure_flag, radius_range_flag, reset_flag, memory_single_bit_flag;
	logic undervoltage_flag, overvoltage_flag, memory_uncorrectable_flag, shadow_parity_flag;
	logic first_update_seen;
	logic [2:0] pwm_hold;
	// clear where the read data is captured, so a flag set while a read is in flight is never lost
	wire err_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == fault_flag_pkg::ADDR_ERROR);
	wire clr = err_read || report_sent;                                    // R3 R23
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			logic_failure_flag        <= 1'b0;
			radius_range_flag         <= 1'b0;
			reset_flag                <= 1'b1;                             // R9
			memory_single_bit_flag    <= 1'b0;
			undervoltage_flag         <= 1'b0;
			overvoltage_flag          <= 1'b0;
			memory_uncorrectable_flag <= 1'b0;
			shadow_parity_flag        <= 1'b0;
			first_update_seen         <= 1'b0;
			pwm_hold                  <= 3'h0;
		end else begin
			if (angle_update) first_update_seen <= 1'b1;
			if (angle_update && pwm_hold != 3'(fault_flag_pkg::PWM_HOLD_UPDATES))
				pwm_hold <= pwm_hold + 3'h1;
			// set wins over clear in every flag
			logic_failure_flag <= logic_cond || (logic_failure_flag && !clr);        // R1 R3
			// masking also drops a flag already raised, so it stops driving the error response
			radius_range_flag  <= (radius_cond && !radius_mask) ||
				(radius_range_flag && !radius_mask && !(clr && !radius_cond));      // R8 R25
			undervoltage_flag  <= uv_cond || (undervoltage_flag && !clr);            // R18
			overvoltage_flag   <= ov_cond || (overvoltage_flag && !clr);             // R21
			if (clr && first_update_seen && !(pwm_mode &&
				pwm_hold != 3'(fault_flag_pkg::PWM_HOLD_UPDATES)))
				reset_flag <= 1'b0;                                            // R9 R12
			// a dip below the reset level starts the reset flag over
			if (por_low_s) begin
				reset_flag        <= 1'b1;                                     // R19
				first_update_seen <= 1'b0;
			end
			if (err_read) memory_single_bit_flag <= 1'b0;                      // R14
			if (mem_read_done && mem_single_bit && !single_mask)
				memory_single_bit_flag <= 1'b1;                                // R14 R15
			if (mem_read_done && mem_multi_bit)
				memory_uncorrectable_flag <= 1'b1;                             // R13 R14 R15
			if ((mem_read_done || ten_tick) && shadow_parity_bad && !parity_mask)
				shadow_parity_flag <= 1'b1;                                    // R16 R17
		end
	end
	wire reset_visible = reset_flag && !reset_mask;                        // R10 R11
	wire [31:0] error_word = {19'h00000, 1'b0, shadow_parity_flag, memory_uncorrectable_flag,
		overvoltage_flag, undervoltage_flag, memory_single_bit_flag, reset_visible,
		radius_range_flag, logic_failure_flag, 4'h0};
	wire crit = memory_uncorrectable_flag || shadow_parity_flag;           // R13 R16
	wire next_err = crit || logic_failure_flag || radius_range_flag || reset_visible ||
		undervoltage_flag || overvoltage_flag;

	// ****************************************
	// output state
	// ****************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			error_response <= 1'b0;
			critical_error <= 1'b0;
			output_hiz     <= 1'b1;
			program_mode   <= 1'b0;
		end else begin
			error_response <= next_err;                                    // R10 R18
			critical_error <= crit;
			program_mode   <= ov_trip && !mem_locked;                      // R21
			output_hiz     <= por_low_s || crit || (ov_trip && !mem_locked); // R19
		end
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic       aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire cfg_hit  = aw_addr == fault_flag_pkg::ADDR_CONFIG;
	wire rd_map   = s_axi_araddr == fault_flag_pkg::ADDR_ERROR || s_axi_araddr == fault_flag_pkg::ADDR_RADIUS ||
		s_axi_araddr == fault_flag_pkg::ADDR_CONFIG || s_axi_araddr == fault_flag_pkg::ADDR_STATUS;
	wire [31:0] status_word = {28'h0000000, program_mode, output_hiz, critical_error, first_update_seen};
	wire [31:0] next_rdata =
		s_axi_araddr == fault_flag_pkg::ADDR_ERROR  ? error_word :
		s_axi_araddr == fault_flag_pkg::ADDR_RADIUS ? {15'h0000, squared_radius} :
		s_axi_araddr == fault_flag_pkg::ADDR_CONFIG ? config_reg :
		s_axi_araddr == fault_flag_pkg::ADDR_STATUS ? status_word : 32'h00000000;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			config_reg <= fault_flag_pkg::CONFIG_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				for (int i = 0; i < 4; i++)
					if (cfg_hit && w_strb[i]) config_reg[8*i +: 8] <= w_data[8*i +: 8];
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= cfg_hit ? fault_flag_pkg::RESP_OKAY : fault_flag_pkg::RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_map ? fault_flag_pkg::RESP_OKAY : fault_flag_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_uncorr_sticky;
		@(posedge clk) disable iff (!resetn) memory_uncorrectable_flag |=> memory_uncorrectable_flag;
	endproperty
	a_uncorr_sticky: assert property (p_uncorr_sticky) else $error("uncorrectable flag dropped"); // R13
	property p_parity_sticky;
		@(posedge clk) disable iff (!resetn) shadow_parity_flag |=> shadow_parity_flag;
	endproperty
	a_parity_sticky: assert property (p_parity_sticky) else $error("parity flag dropped"); // R16
	property p_radius_mask;
		@(posedge clk) disable iff (!resetn) (radius_mask && !radius_range_flag) |=> !radius_range_flag;
	endproperty
	a_radius_mask: assert property (p_radius_mask) else $error("masked radius flag set"); // R8
	property p_reset_hold;
		@(posedge clk) disable iff (!resetn) !first_update_seen |-> reset_flag;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("reset flag cleared early"); // R9
	property p_uv_set;
		@(posedge clk) disable iff (!resetn) uv_cond |=> undervoltage_flag;
	endproperty
	a_uv_set: assert property (p_uv_set) else $error("undervoltage not flagged"); // R18
	property p_ov_unlocked;
		@(posedge clk) disable iff (!resetn) (!mem_locked && !overvoltage_flag) |=> !overvoltage_flag;
	endproperty
	a_ov_unlocked: assert property (p_ov_unlocked) else $error("overvoltage flagged unlocked"); // R21
	property p_crit_out;
		@(posedge clk) disable iff (!resetn) crit |=> critical_error && error_response;
	endproperty
	a_crit_out: assert property (p_crit_out) else $error("critical state not driven"); // R13
	property p_logic_set;
		@(posedge clk) disable iff (!resetn) logic_cond |=> logic_failure_flag;
	endproperty
	a_logic_set: assert property (p_logic_set) else $error("logic failure not flagged"); // R1

	property p_por_flag;
		@(posedge clk) disable iff (!resetn) por_low_s |=> reset_flag;
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("reset flag not raised below reset level"); // R19

	property p_por_hiz;
		@(posedge clk) disable iff (!resetn) por_low_s |=> output_hiz;
	endproperty
	a_por_hiz: assert property (p_por_hiz) else $error("output driven below reset level"); // R19

	property p_parity_mask;
		@(posedge clk) disable iff (!resetn) (parity_mask && !shadow_parity_flag) |=> !shadow_parity_flag;
	endproperty
	a_parity_mask: assert property (p_parity_mask) else $error("masked parity flag set"); // R25

	property p_single_clear;
		@(posedge clk) disable iff (!resetn) (err_read && !mem_read_done) |=> !memory_single_bit_flag;
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("single-bit flag kept after read"); // R14

	c_crit: cover property (@(posedge clk) disable iff (!resetn) critical_error);
	c_uv: cover property (@(posedge clk) disable iff (!resetn) undervoltage_flag ##1 !undervoltage_flag);
	c_radius: cover property (@(posedge clk) disable iff (!resetn) radius_range_flag);
	c_reset_clr: cover property (@(posedge clk) disable iff (!resetn) reset_flag ##1 !reset_flag);
endmodule
`default_nettype wire

// >>> testbench/output_receiver.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// receiver at the far end of the output protocol
// ****************************************
// acknowledges one frame every FRAME cycles while enabled and error_response is high; a frame carries the flags
module output_receiver #(
	parameter int FRAME = 16
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic enable,
	input  wire logic error_response,
	output logic      report_sent
);
	logic [7:0] count;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count       <= 8'h00;
			report_sent <= 1'b0;
		end else begin
			count       <= (count == 8'(FRAME - 1)) ? 8'h00 : count + 8'h01;
			report_sent <= enable && error_response && count == 8'(FRAME - 1);
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [31:0] BASE = 32'h0140_4000;
	logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, report_sent, err_resp, crit, hiz, prog;
	logic        upd = 1'b0, smp = 1'b0, outv = 1'b0, mem_done = 1'b0, mem_single = 1'b0, mem_multi = 1'b0;
	logic        parity_bad = 1'b0, por_low = 1'b0, rx_en = 1'b0;
	logic [15:0] ch_a = 16'h0800, ch_b = 16'h0000, st_res = 16'h0000;
	logic [3:0]  trips = 4'h0;
	int          error_cnt = 0, n_compared = 0, i;
	logic [31:0] t_cfg[8] = '{32'h00, 32'h00, 32'h10, 32'h10, 32'h40, 32'h40, 32'h60, 32'h60};
	logic [3:0]  t_trip[8] = '{4'b0001, 4'b0010, 4'b0010, 4'b0001, 4'b1000, 4'b0100, 4'b0100, 4'b1000};
	logic        t_exp[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	always #12.5 clk = ~clk;
	fault_flag_monitor i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .angle_update(upd),
		.first_channel_value(ch_a), .second_channel_value(ch_b), .samples_ready(smp), .angle_out_valid(outv),
		.selftest_result(st_res), .selftest_expected(16'h0000), .mem_read_done(mem_done),
		.mem_single_bit(mem_single), .mem_multi_bit(mem_multi), .shadow_parity_bad(parity_bad),
		.uv_low_trip(trips[0]), .uv_high_trip(trips[1]), .ov_low_trip(trips[2]), .ov_high_trip(trips[3]),
		.por_level_low(por_low), .report_sent(report_sent), .error_response(err_resp), .critical_error(crit),
		.output_hiz(hiz), .program_mode(prog));
	output_receiver #(.FRAME(16)) i_rx (.clk(clk), .resetn(resetn), .enable(rx_en), .error_response(err_resp),
		.report_sent(report_sent));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// every bus task starts one edge late so no signal is assigned twice in a time step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 100) begin
			check("write timeout", 1, 0);
			final_report();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata; r = rresp;
		rready <= 1'b0;
		if (n == 100) begin
			check("read timeout", 1, 0);
			final_report();
		end
	endtask
	task automatic rbit(input int b, input logic e);
		rd(fault_flag_pkg::ADDR_ERROR);
		check("error bit", 32'(d[b]), 32'(e));
	endtask
	// n update periods, each with a prompt angle output so the watchdog stays quiet
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk) upd <= 1'b1; smp <= 1'b1;
			@(posedge clk) upd <= 1'b0; smp <= 1'b0;
			repeat (3) @(posedge clk);
			outv <= 1'b1;
			@(posedge clk) outv <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic pulse_mem();
		@(posedge clk) mem_done <= 1'b1;
		@(posedge clk) mem_done <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic rst();
		@(posedge clk) resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
	endtask
	task automatic radius_case(input logic [15:0] a, input logic [15:0] b, input logic e);
		@(posedge clk) ch_a <= a; ch_b <= b;
		tick(1);
		rbit(fault_flag_pkg::BIT_RADIUS, e);
		@(posedge clk) ch_a <= 16'h0800; ch_b <= 16'h0000;
		tick(1);
		rd(fault_flag_pkg::ADDR_ERROR);
		rbit(fault_flag_pkg::BIT_RADIUS, 1'b0);
	endtask
	initial begin
		#(25ns * 40000);
		error_cnt++;
		final_report();
	end
	initial begin
		mem_single <= 1'b1;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		check("response after reset", 32'(err_resp), 1);
		pulse_mem();
		rd(fault_flag_pkg::ADDR_CONFIG);
		check("config reset", d, fault_flag_pkg::CONFIG_RESET);
		wr(fault_flag_pkg::ADDR_CONFIG, BASE);
		check("config write resp", 32'(r), 32'(fault_flag_pkg::RESP_OKAY));
		rd(fault_flag_pkg::ADDR_ERROR);
		check("error after power on", d, 32'h0000_00c0);
		rd(fault_flag_pkg::ADDR_ERROR);
		check("reset flag before update", d, 32'h0000_0040);
		tick(1);
		rd(fault_flag_pkg::ADDR_ERROR);
		rd(fault_flag_pkg::ADDR_ERROR);
		check("flags cleared", d, 32'h0);
		rd(8'h10);
		check("unmapped read", {r, d[29:0]}, {fault_flag_pkg::RESP_SLVERR, 30'h0});
		wr(fault_flag_pkg::ADDR_ERROR, 32'h0);
		check("read only write", 32'(r), 32'(fault_flag_pkg::RESP_SLVERR));
		@(posedge clk) ch_a <= 16'h0a7f; ch_b <= 16'h057f;
		tick(1);
		rd(fault_flag_pkg::ADDR_RADIUS);
		check("squared radius", d, 32'd500);
		radius_case(16'h0a7f, 16'h057f, 1'b1);
		radius_case(16'h0a00, 16'h0000, 1'b1);
		radius_case(16'h09ff, 16'h0000, 1'b0);
		radius_case(16'h0200, 16'h0000, 1'b1);
		radius_case(16'h0280, 16'h0000, 1'b0);
		wr(fault_flag_pkg::ADDR_CONFIG, BASE | 32'h200);
		@(posedge clk) ch_a <= 16'h0a00;
		tick(2);
		rbit(fault_flag_pkg::BIT_RADIUS, 1'b0);
		tick(1);
		rbit(fault_flag_pkg::BIT_RADIUS, 1'b1);
		wr(fault_flag_pkg::ADDR_CONFIG, BASE | 32'h1);
		tick(3);
		rbit(fault_flag_pkg::BIT_RADIUS, 1'b0);
		rd(fault_flag_pkg::ADDR_RADIUS);
		check("radius while masked", d, 32'd400);
		@(posedge clk) ch_a <= 16'h0800;
		tick(1);
		wr(fault_flag_pkg::ADDR_CONFIG, BASE);
		@(posedge clk) st_res <= 16'h0001;
		for (i = 0; i < 12 && err_resp !== 1'b1; i++) tick(1);
		check("logic check fires", 32'(i <= 10), 1);
		@(posedge clk) st_res <= 16'h0000;
		tick(10);
		rbit(fault_flag_pkg::BIT_LOGIC, 1'b1);
		rbit(fault_flag_pkg::BIT_LOGIC, 1'b0);
		@(posedge clk) st_res <= 16'h0001;
		tick(9);
		rbit(fault_flag_pkg::BIT_LOGIC, 1'b0);
		tick(1);
		rbit(fault_flag_pkg::BIT_LOGIC, 1'b1);
		@(posedge clk) st_res <= 16'h0000;
		tick(10);
		rd(fault_flag_pkg::ADDR_ERROR);
		rd(fault_flag_pkg::ADDR_ERROR);
		for (i = 0; i < 8; i++) begin
			wr(fault_flag_pkg::ADDR_CONFIG, BASE | t_cfg[i]);
			@(posedge clk) trips <= t_trip[i];
			repeat (6) @(posedge clk);
			check("supply response", 32'(err_resp), 32'(t_exp[i]));
			rbit(i < 4 ? fault_flag_pkg::BIT_UNDERV : fault_flag_pkg::BIT_OVERV, t_exp[i]);
			@(posedge clk) trips <= 4'h0;
			repeat (6) @(posedge clk);
			rd(fault_flag_pkg::ADDR_ERROR);
			rbit(i < 4 ? fault_flag_pkg::BIT_UNDERV : fault_flag_pkg::BIT_OVERV, 1'b0);
		end
		wr(fault_flag_pkg::ADDR_CONFIG, BASE);
		@(posedge clk) trips <= 4'b0001;
		repeat (6) @(posedge clk);
		trips <= 4'h0;
		rx_en <= 1'b1;
		repeat (40) @(posedge clk);
		check("cleared by report", 32'(err_resp), 0);
		rx_en <= 1'b0;
		trips <= 4'b1000;
		repeat (6) @(posedge clk);
		check("program mode", {30'h0, prog, hiz}, 32'h3);
		rbit(fault_flag_pkg::BIT_OVERV, 1'b0);
		trips <= 4'h0;
		por_low <= 1'b1;
		repeat (6) @(posedge clk);
		check("hiz below reset level", 32'(hiz), 1);
		por_low <= 1'b0;
		repeat (6) @(posedge clk);
		check("reset flag on recovery", 32'(err_resp), 1);
		mem_single <= 1'b0;
		parity_bad <= 1'b1;
		rst();
		wr(fault_flag_pkg::ADDR_CONFIG, BASE | 32'hc);
		repeat (2) @(posedge clk);
		check("reset flag masked", 32'(err_resp), 0);
		pulse_mem();
		mem_multi <= 1'b1;
		repeat (6) @(posedge clk);
		check("parity masked, late multi ignored", 32'(crit), 0);
		rbit(fault_flag_pkg::BIT_PARITY, 1'b0);
		mem_multi <= 1'b0;
		wr(fault_flag_pkg::ADDR_CONFIG, BASE | 32'h8);
		tick(10);
		rbit(fault_flag_pkg::BIT_PARITY, 1'b1);
		rbit(fault_flag_pkg::BIT_PARITY, 1'b1);
		check("parity critical", 32'(crit), 1);
		parity_bad <= 1'b0;
		mem_multi <= 1'b1;
		rst();
		pulse_mem();
		rbit(fault_flag_pkg::BIT_UNCORR, 1'b1);
		rbit(fault_flag_pkg::BIT_UNCORR, 1'b1);
		check("multi bit critical", 32'(crit), 1);
		final_report();
	end
endmodule
`default_nettype wire
